// ==== rtl/dect_defines.vh ====
// Constants for the dual event counter and timer block.
// Assumes a 20 MHz core clock and a simple strobe register port.
`ifndef DECT_DEFINES_VH
`define DECT_DEFINES_VH

// Register byte offsets.
`define DECT_REG_UNIT_SELECT    8'h00
`define DECT_REG_INCREMENT      8'h04
`define DECT_REG_START_TRIGGER  8'h08
`define DECT_REG_CLEAR          8'h0C
`define DECT_REG_DELAY          8'h10
`define DECT_REG_DURATION       8'h14
`define DECT_REG_PRESENT_COUNT  8'h18
`define DECT_REG_STATE          8'h1C
`define DECT_REG_COUNT_AT_CLEAR 8'h20
`define DECT_REG_IRQ_STATUS     8'h24
`define DECT_REG_IRQ_MASK       8'h28

// Source and activation field positions inside the source registers.
`define DECT_SRC_MSB 4
`define DECT_ACT_MSB 10
`define DECT_ACT_LSB 8

// Source codes.
`define DECT_SRC_OFF        5'h00
`define DECT_SRC_TICK       5'h01
`define DECT_SRC_C0_START   5'h0A
`define DECT_SRC_C1_END     5'h0D

// Activation modes.
`define DECT_ACT_LEVEL_LOW  3'h0
`define DECT_ACT_LEVEL_HIGH 3'h1
`define DECT_ACT_FALLING    3'h2
`define DECT_ACT_RISING     3'h3
`define DECT_ACT_ANY_EDGE   3'h4

// Counter states.
`define DECT_ST_IDLE   3'h0
`define DECT_ST_WAIT   3'h1
`define DECT_ST_DELAY  3'h2
`define DECT_ST_ACTIVE 3'h3
`define DECT_ST_DONE   3'h4

// Microsecond pulse timing.
`define DECT_CLK_PERIOD_NS 50
`define DECT_TICK_NS       1000
`define DECT_TICK_CYCLES   (`DECT_TICK_NS / `DECT_CLK_PERIOD_NS)

`endif

// ==== rtl/dect_counter_timer.v ====
// Two event counters and timers with their register port and interrupt.
// Assumes line inputs are asynchronous pins and all other sources share core_clk_i.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "dect_defines.vh"
`default_nettype none

module dect_counter_timer (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        reset_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wr_data_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rd_data_o,
  // Event sources
  input  wire [3:0]  line_i,
  input  wire [3:0]  software_output_bit_i,
  input  wire [1:0]  combinational_unit_out_i,
  input  wire        exposure_start_i,
  input  wire        exposure_end_i,
  input  wire        frame_trigger_pending_i,
  // Events and interrupt
  output reg  [1:0]  tally_start_event_o,
  output reg  [1:0]  tally_end_event_o,
  output wire        irq_o
);

  reg          tally_unit_select_r;
  reg  [4:0]   inc_src_r   [0:1];
  reg  [2:0]   inc_act_r   [0:1];
  reg  [4:0]   trig_src_r  [0:1];
  reg  [2:0]   trig_act_r  [0:1];
  reg  [4:0]   clr_src_r   [0:1];
  reg  [2:0]   clr_act_r   [0:1];
  reg  [31:0]  delay_r     [0:1];
  reg  [31:0]  duration_r  [0:1];
  reg  [31:0]  count_r     [0:1];
  reg  [31:0]  at_clear_r  [0:1];
  reg  [2:0]   state_r     [0:1];
  reg  [3:0]   irq_status_r;
  reg  [3:0]   irq_mask_r;
  reg  [3:0]   line_meta_r;
  reg  [3:0]   line_sync_r;
  reg  [4:0]   tick_cnt_r;
  reg          microsecond_pulse_r;
  reg  [31:0]  src_prev_r;
  reg  [31:0]  rd_nxt;
  wire [31:0]  src_now;
  wire [3:0]   irq_events;
  wire         sel;
  wire [1:0]   inc_hit;
  wire [1:0]   trig_hit;
  wire [1:0]   clr_hit;
  wire [1:0]   sw_at_clear;
  wire [31:0]  cnt_inc     [0:1];
  integer      i;
  integer      u;

  // The tick counter wraps on its last cycle so that one pulse marks each microsecond.
  localparam integer TICK_LAST_I = `DECT_TICK_CYCLES - 1;
  localparam [4:0]   TICK_LAST   = TICK_LAST_I[4:0];

  assign sel = tally_unit_select_r;

  // Line pins are synchronised before any source logic sees them.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      line_meta_r <= 4'h0;
      line_sync_r <= 4'h0;
    end else begin
      line_meta_r <= line_i;
      line_sync_r <= line_meta_r;
    end
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_r          <= 5'h00;
      microsecond_pulse_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r          <= 5'h00;
      microsecond_pulse_r <= 1'b1;
    end else begin
      tick_cnt_r          <= tick_cnt_r + 5'h01;
      microsecond_pulse_r <= 1'b0;
    end
  end

  // Bit positions equal the source codes; code 0 is the off setting and always low.
  assign src_now = {13'h0000, frame_trigger_pending_i, exposure_end_i, exposure_start_i,
                    combinational_unit_out_i, tally_end_event_o, tally_start_event_o,
                    software_output_bit_i, line_sync_r, microsecond_pulse_r, 1'b0};

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      src_prev_r <= 32'h0000_0000;
    end else begin
      src_prev_r <= src_now;
    end
  end

  // Tick and counter events are already pulses, so they count once each whatever the mode.
  function qualify;
    input [4:0]  code;
    input [2:0]  act;
    input [31:0] now;
    input [31:0] prev;
    reg          cur;
    reg          old;
    begin
      cur = now[code];
      old = prev[code];
      if (code == `DECT_SRC_OFF) begin
        qualify = 1'b0;
      end else if (code == `DECT_SRC_TICK ||
                   (code >= `DECT_SRC_C0_START && code <= `DECT_SRC_C1_END)) begin
        qualify = cur;
      end else begin
        case (act)
          `DECT_ACT_LEVEL_LOW:  qualify = ~cur;
          `DECT_ACT_LEVEL_HIGH: qualify = cur;
          `DECT_ACT_FALLING:    qualify = old & ~cur;
          `DECT_ACT_RISING:     qualify = ~old & cur;
          `DECT_ACT_ANY_EDGE:   qualify = old ^ cur;
          default:              qualify = 1'b0;
        endcase
      end
    end
  endfunction

  // Configuration registers; the source, delay and duration registers are written for the selected counter.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tally_unit_select_r <= 1'b0;
      irq_mask_r          <= 4'h0;
      for (i = 0; i < 2; i = i + 1) begin
        inc_src_r[i]  <= `DECT_SRC_OFF;
        inc_act_r[i]  <= `DECT_ACT_RISING;
        trig_src_r[i] <= `DECT_SRC_OFF;
        trig_act_r[i] <= `DECT_ACT_RISING;
        clr_src_r[i]  <= `DECT_SRC_OFF;
        clr_act_r[i]  <= `DECT_ACT_RISING;
        delay_r[i]    <= 32'h0000_0000;
        duration_r[i] <= 32'h0000_0000;
      end
    end else if (wr_i) begin
      case (addr_i)
        `DECT_REG_UNIT_SELECT: tally_unit_select_r <= wr_data_i[0];
        `DECT_REG_INCREMENT: begin
          inc_src_r[sel] <= wr_data_i[`DECT_SRC_MSB:0];
          inc_act_r[sel] <= wr_data_i[`DECT_ACT_MSB:`DECT_ACT_LSB];
        end
        `DECT_REG_START_TRIGGER: begin
          trig_src_r[sel] <= wr_data_i[`DECT_SRC_MSB:0];
          trig_act_r[sel] <= wr_data_i[`DECT_ACT_MSB:`DECT_ACT_LSB];
          if (wr_data_i[`DECT_SRC_MSB:0] != `DECT_SRC_OFF) begin
            clr_src_r[sel] <= `DECT_SRC_OFF;
          end
        end
        `DECT_REG_CLEAR: begin
          clr_src_r[sel] <= wr_data_i[`DECT_SRC_MSB:0];
          clr_act_r[sel] <= wr_data_i[`DECT_ACT_MSB:`DECT_ACT_LSB];
          if (wr_data_i[`DECT_SRC_MSB:0] != `DECT_SRC_OFF) begin
            trig_src_r[sel] <= `DECT_SRC_OFF;
          end
        end
        `DECT_REG_DELAY:     delay_r[sel]    <= wr_data_i;
        `DECT_REG_DURATION:  duration_r[sel] <= wr_data_i;
        `DECT_REG_IRQ_MASK:  irq_mask_r      <= wr_data_i[3:0];
        default: ;
      endcase
    end
  end

  // Per-counter source hits, read by index in the state machine process below.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_unit
      assign inc_hit[g]     = qualify(inc_src_r[g], inc_act_r[g], src_now, src_prev_r);
      assign trig_hit[g]    = qualify(trig_src_r[g], trig_act_r[g], src_now, src_prev_r);
      assign clr_hit[g]     = qualify(clr_src_r[g], clr_act_r[g], src_now, src_prev_r);
      assign cnt_inc[g]     = count_r[g] + {31'h0000_0000, inc_hit[g]};
      assign sw_at_clear[g] = wr_i && addr_i == `DECT_REG_COUNT_AT_CLEAR && sel == g;
    end
  endgenerate

  // Both counters share one process so that every event output and array has a single driver.
  // A clear outranks everything else in the same cycle, including a start or end.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tally_start_event_o <= 2'b00;
      tally_end_event_o   <= 2'b00;
      for (u = 0; u < 2; u = u + 1) begin
        state_r[u]    <= `DECT_ST_IDLE;
        count_r[u]    <= 32'h0000_0000;
        at_clear_r[u] <= 32'h0000_0000;
      end
    end else begin
      tally_start_event_o <= 2'b00;
      tally_end_event_o   <= 2'b00;
      for (u = 0; u < 2; u = u + 1) begin
        if (clr_hit[u]) begin
          at_clear_r[u] <= count_r[u];
          count_r[u]    <= 32'h0000_0000;
          state_r[u]    <= `DECT_ST_IDLE;
        end else begin
          if (sw_at_clear[u]) begin
            at_clear_r[u] <= wr_data_i;
          end
          if (inc_src_r[u] == `DECT_SRC_OFF) begin
            state_r[u] <= `DECT_ST_IDLE;
          end else begin
            case (state_r[u])
              `DECT_ST_IDLE: begin
                count_r[u] <= 32'h0000_0000;
                if (trig_src_r[u] != `DECT_SRC_OFF) begin
                  state_r[u] <= `DECT_ST_WAIT;
                end else begin
                  state_r[u] <= `DECT_ST_DELAY;
                end
              end
              `DECT_ST_WAIT: begin
                if (trig_hit[u]) begin
                  count_r[u] <= 32'h0000_0000;
                  state_r[u] <= `DECT_ST_DELAY;
                end
              end
              `DECT_ST_DELAY: begin
                if (cnt_inc[u] >= delay_r[u]) begin
                  tally_start_event_o[u] <= 1'b1;
                  count_r[u]             <= 32'h0000_0000;
                  state_r[u]             <= `DECT_ST_ACTIVE;
                end else begin
                  count_r[u] <= cnt_inc[u];
                end
              end
              `DECT_ST_ACTIVE: begin
                count_r[u] <= cnt_inc[u];
                if (cnt_inc[u] >= duration_r[u]) begin
                  tally_end_event_o[u] <= 1'b1;
                  state_r[u]           <= `DECT_ST_DONE;
                end
              end
              `DECT_ST_DONE: begin
                // A fresh trigger re-arms the counter, so a triggered counter acts as a one-shot generator.
                if (trig_src_r[u] != `DECT_SRC_OFF && trig_hit[u]) begin
                  count_r[u] <= 32'h0000_0000;
                  state_r[u] <= `DECT_ST_DELAY;
                end
              end
              default: state_r[u] <= `DECT_ST_IDLE;
            endcase
          end
        end
      end
    end
  end

  // Status bits: counter 0 start, counter 0 end, counter 1 start, counter 1 end.
  assign irq_events = {tally_end_event_o[1], tally_start_event_o[1],
                       tally_end_event_o[0], tally_start_event_o[0]};

  // A read clears the status, but an event in that same cycle survives the clear.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status_r <= 4'h0;
    end else if (rd_i && addr_i == `DECT_REG_IRQ_STATUS) begin
      irq_status_r <= irq_events;
    end else begin
      irq_status_r <= irq_status_r | irq_events;
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (addr_i)
      `DECT_REG_UNIT_SELECT:    rd_nxt = {31'h0000_0000, sel};
      `DECT_REG_INCREMENT:      rd_nxt = {21'h00_0000, inc_act_r[sel], 3'h0, inc_src_r[sel]};
      `DECT_REG_START_TRIGGER:  rd_nxt = {21'h00_0000, trig_act_r[sel], 3'h0, trig_src_r[sel]};
      `DECT_REG_CLEAR:          rd_nxt = {21'h00_0000, clr_act_r[sel], 3'h0, clr_src_r[sel]};
      `DECT_REG_DELAY:          rd_nxt = delay_r[sel];
      `DECT_REG_DURATION:       rd_nxt = duration_r[sel];
      `DECT_REG_PRESENT_COUNT:  rd_nxt = count_r[sel];
      `DECT_REG_STATE:          rd_nxt = {29'h0000_0000, state_r[sel]};
      `DECT_REG_COUNT_AT_CLEAR: rd_nxt = at_clear_r[sel];
      `DECT_REG_IRQ_STATUS:     rd_nxt = {28'h000_0000, irq_status_r};
      `DECT_REG_IRQ_MASK:       rd_nxt = {28'h000_0000, irq_mask_r};
      default:                  rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data are valid only in the cycle after the strobe and zero otherwise.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rd_data_o <= rd_nxt;
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ==== sim/dect_counter_timer_sva.sv ====
// Checker for the dual counter and timer block, watching its top-level ports only.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module dect_counter_timer_chk (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // Register port
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  // Events and interrupt
  input wire logic [1:0]  tally_start_event_o,
  input wire logic [1:0]  tally_end_event_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_start0_single; tally_start_event_o[0] |=> !tally_start_event_o[0]; endproperty
  a_start0_single: assert property (p_start0_single) else $error("start pulse 0 too long");
  property p_start1_single; tally_start_event_o[1] |-> ##1 tally_start_event_o[1] == 1'b0; endproperty
  a_start1_single: assert property (p_start1_single) else $error("start pulse 1 too long");
  property p_end0_single; $rose(tally_end_event_o[0]) |=> $fell(tally_end_event_o[0]); endproperty
  a_end0_single: assert property (p_end0_single) else $error("end pulse 0 too long");
  property p_end1_single; tally_end_event_o[1] |=> tally_end_event_o[1] == 1'b0; endproperty
  a_end1_single: assert property (p_end1_single) else $error("end pulse 1 too long");
  property p_start_end_apart; tally_start_event_o[1] |-> !tally_end_event_o[1]; endproperty
  a_start_end_apart: assert property (p_start_end_apart) else $error("start and end together");
  property p_rd_quiet; !$past(rd_i) |-> rd_data_o == 32'h0000_0000; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data without a read");
  property p_irq_fall; $fell(irq_o) |-> ($past(rd_i) || $past(wr_i)); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped on its own");
  // Sources are Off after reset, so no event may fire in the first two cycles after reset falls.
  property p_post_reset;
    $fell(reset_i) |-> (tally_start_event_o == 2'b00 && tally_end_event_o == 2'b00)[*2];
  endproperty
  a_post_reset: assert property (p_post_reset) else $error("event right after reset");

  c_start: cover property (tally_start_event_o[0]);
  c_end: cover property (tally_end_event_o[0]);
  c_irq: cover property ($rose(irq_o));
endmodule

bind dect_counter_timer dect_counter_timer_chk chk_u (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .tally_start_event_o(tally_start_event_o), .tally_end_event_o(tally_end_event_o), .irq_o(irq_o)
);
`default_nettype wire

// ==== sim/dect_src_model.sv ====
// Model of the device-internal signals that feed the counters.
// Assumes the bench requests levels and pulses; outputs change only at the clock edge.
`timescale 1ns/10ps
`default_nettype none

module dect_src_model (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Requests from the bench
  input  wire logic [7:0] lvl_i,
  input  wire logic       expo_req_i,
  // Source signals
  output var  logic [3:0] software_output_bit_o,
  output var  logic [3:0] line_o,
  output var  logic       exposure_start_o
);
  // Exposure start is a registered one-cycle pulse, as the sensor side would give it.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      software_output_bit_o <= 4'h0;
      line_o                <= 4'h0;
      exposure_start_o      <= 1'b0;
    end else begin
      software_output_bit_o <= lvl_i[3:0];
      line_o                <= lvl_i[7:4];
      exposure_start_o      <= expo_req_i;
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_dect_counter_timer.sv ====
// Self-checking bench for the dual counter and timer block.
// Assumes a 20 MHz clock and the register map of the block's defines header.
`timescale 1ns/10ps
`include "dect_defines.vh"
`default_nettype none

module test_dect_counter_timer;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rd_data_o;
  logic [3:0]  line_w;
  logic [3:0]  sw_w;
  logic        expo_w;
  logic [7:0]  lvl_r = 8'h00;
  logic        expo_req_r = 1'b0;
  logic [3:0]  misc_r = 4'h0;
  logic [1:0]  tally_start_event_o;
  logic [1:0]  tally_end_event_o;
  logic        irq_o;
  logic [31:0] d;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc;

  initial forever #25 core_clk_i = ~core_clk_i;

  dect_src_model src_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .lvl_i(lvl_r), .expo_req_i(expo_req_r),
    .software_output_bit_o(sw_w), .line_o(line_w), .exposure_start_o(expo_w));

  dect_counter_timer dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .line_i(line_w), .software_output_bit_i(sw_w),
    .combinational_unit_out_i(misc_r[1:0]), .exposure_start_i(expo_w), .exposure_end_i(misc_r[2]),
    .frame_trigger_pending_i(misc_r[3]), .tally_start_event_o(tally_start_event_o),
    .tally_end_event_o(tally_end_event_o), .irq_o(irq_o));

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1; addr_i <= a; wr_data_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Waits for a start (end_sel 0) or end (end_sel 1) pulse; cyc holds the cycles waited.
  task automatic wait_ev(input bit end_sel, input int idx, input int bound);
    for (cyc = 1; cyc <= bound; cyc++) begin
      @(posedge core_clk_i);
      #1;
      if ((end_sel ? tally_end_event_o[idx] : tally_start_event_o[idx]) === 1'b1) return;
    end
    check(32'h0000_0000, 32'h0000_0001);
    results();
  endtask

  task automatic t_reset_values;
    rd(`DECT_REG_INCREMENT); check(d, 32'h0000_0300);
    rd(`DECT_REG_STATE); check(d, {29'h0, `DECT_ST_IDLE});
    rd(8'h30); check(d, 32'h0000_0000);
  endtask

  task automatic t_tick_timer;
    wr(`DECT_REG_UNIT_SELECT, 32'h0000_0000);
    wr(`DECT_REG_IRQ_MASK, 32'h0000_0003);
    wr(`DECT_REG_DELAY, 32'h0000_0002);
    wr(`DECT_REG_DURATION, 32'h0000_0001);
    wr(`DECT_REG_INCREMENT, 32'h0000_0301);
    wait_ev(1'b0, 0, 100);
    check(32'(cyc > `DECT_TICK_CYCLES), 32'h0000_0001);
    wait_ev(1'b1, 0, 100);
    check(32'(cyc), 32'(`DECT_TICK_CYCLES));
    check(32'(irq_o), 32'h0000_0001);
    rd(`DECT_REG_STATE); check(d, {29'h0, `DECT_ST_DONE});
    rd(`DECT_REG_IRQ_STATUS); check(d, 32'h0000_0003);
    check(32'(irq_o), 32'h0000_0000);
  endtask

  // Counter 1 waits on a user output edge, then counts exposure starts; its interrupts stay masked.
  task automatic t_trigger_and_clear;
    wr(`DECT_REG_UNIT_SELECT, 32'h0000_0001);
    wr(`DECT_REG_CLEAR, 32'h0000_0302);
    wr(`DECT_REG_START_TRIGGER, 32'h0000_0306);
    rd(`DECT_REG_CLEAR); check(d & 32'h0000_001F, 32'h0000_0000);
    wr(`DECT_REG_DELAY, 32'h0000_0001);
    wr(`DECT_REG_DURATION, 32'h0000_0002);
    wr(`DECT_REG_INCREMENT, 32'h0000_0310);
    rd(`DECT_REG_STATE); check(d, {29'h0, `DECT_ST_WAIT});
    lvl_r <= 8'h01;
    idle(3);
    rd(`DECT_REG_STATE); check(d, {29'h0, `DECT_ST_DELAY});
    expo_req_r <= 1'b1;
    @(posedge core_clk_i);
    expo_req_r <= 1'b0;
    wait_ev(1'b0, 1, 20);
    check(32'(irq_o), 32'h0000_0000);
    rd(`DECT_REG_STATE); check(d, {29'h0, `DECT_ST_ACTIVE});
    expo_req_r <= 1'b1;
    @(posedge core_clk_i);
    expo_req_r <= 1'b0;
    idle(3);
    rd(`DECT_REG_PRESENT_COUNT); check(d, 32'h0000_0001);
    wr(`DECT_REG_CLEAR, 32'h0000_0307);
    rd(`DECT_REG_START_TRIGGER); check(d & 32'h0000_001F, 32'h0000_0000);
    lvl_r <= 8'h03;
    idle(3);
    rd(`DECT_REG_COUNT_AT_CLEAR); check(d, 32'h0000_0001);
    rd(`DECT_REG_PRESENT_COUNT); check(d, 32'h0000_0000);
    wr(`DECT_REG_UNIT_SELECT, 32'h0000_0000);
    rd(`DECT_REG_STATE); check(d, {29'h0, `DECT_ST_DONE});
  endtask

  // Counter 0 stays in its delay phase while level, falling and any-edge modes add to its count.
  task automatic t_activation;
    wr(`DECT_REG_DELAY, 32'h0000_0100);
    wr(`DECT_REG_INCREMENT, 32'h0000_0000);
    wr(`DECT_REG_INCREMENT, 32'h0000_0108);
    lvl_r <= 8'h07;
    idle(4);
    lvl_r <= 8'h03;
    idle(2);
    rd(`DECT_REG_PRESENT_COUNT); check(d, 32'h0000_0004);
    wr(`DECT_REG_INCREMENT, 32'h0000_0208);
    lvl_r <= 8'h07;
    idle(2);
    lvl_r <= 8'h03;
    idle(3);
    rd(`DECT_REG_PRESENT_COUNT); check(d, 32'h0000_0005);
    wr(`DECT_REG_INCREMENT, 32'h0000_0412);
    misc_r <= 4'h8;
    idle(2);
    misc_r <= 4'h0;
    idle(3);
    rd(`DECT_REG_PRESENT_COUNT); check(d, 32'h0000_0007);
  endtask

  initial begin
    idle(10);
    reset_i <= 1'b0;
    t_reset_values();
    t_tick_timer();
    t_trigger_and_clear();
    t_activation();
    results();
  end
endmodule
`default_nettype wire
